// ---- pkg/lpsm_pkg.sv ----
package lpsm_pkg;

  typedef enum logic [2:0] {
    LPSM_MODE_RUN      = 3'h0,
    LPSM_MODE_VLP_STOP = 3'h1,
    LPSM_MODE_LL_STOP  = 3'h2,
    LPSM_MODE_VLL3     = 3'h3,
    LPSM_MODE_VLL2     = 3'h4,
    LPSM_MODE_VLL1     = 3'h5,
    LPSM_MODE_BATT     = 3'h6
  } lpsm_mode_t;

  typedef enum logic [2:0] {
    LPSM_ST_RUN     = 3'h0,
    LPSM_ST_WAIT    = 3'h1,
    LPSM_ST_STOP    = 3'h2,
    LPSM_ST_RSTFLOW = 3'h3,
    LPSM_ST_OFF     = 3'h4
  } lpsm_state_t;

  // power and clock controls driven into the chip
  typedef struct packed {
    logic periph_clk_en;
    logic low_voltage_detect_en;
    logic nested_vector_irq_ctrl_en;
    logic async_wakeup_irq_ctrl_en;
    logic low_leakage_wakeup_unit_en;
    logic lp_periph_en;
    logic adc_pin_irq_en;
    logic sram_upper_pwr;
    logic sram_upper_part_pwr;
    logic sram_lower_pwr;
    logic sysreg_file_pwr;
    logic backup_reg_file_pwr;
    logic pin_hold;
    logic core_pwr;
  } lpsm_ctrl_t;

  // equals the run map, so the first edge after reset changes no control
  localparam lpsm_ctrl_t LPSM_CTRL_RESET = 14'h39FD;
  localparam int unsigned LPSM_RSTFLOW_NS   = 1000;
  localparam int unsigned LPSM_CLK_NS       = 50;
  localparam int unsigned LPSM_RSTFLOW_CYC  = (LPSM_RSTFLOW_NS + LPSM_CLK_NS - 1) / LPSM_CLK_NS;

endpackage : lpsm_pkg

// ---- hdl/lpsm_ctrl_map.sv ----
`timescale 1ns/100ps
// maps the occupied mode onto the power and clock controls
module lpsm_ctrl_map (
  input  wire lpsm_pkg::lpsm_state_t state_i,
  input  wire lpsm_pkg::lpsm_mode_t  mode_i,
  output lpsm_pkg::lpsm_ctrl_t       ctrl_o
);

  always_comb begin
    ctrl_o = '0;
    ctrl_o.core_pwr            = 1'b1;
    ctrl_o.backup_reg_file_pwr = 1'b1;
    ctrl_o.pin_hold            = 1'b0;
    if (state_i == lpsm_pkg::LPSM_ST_OFF) begin
      ctrl_o.core_pwr = 1'b0;
    end else if (state_i != lpsm_pkg::LPSM_ST_STOP) begin
      ctrl_o.periph_clk_en             = 1'b1;
      ctrl_o.low_voltage_detect_en     = 1'b1;
      ctrl_o.nested_vector_irq_ctrl_en = 1'b1;
      ctrl_o.lp_periph_en              = 1'b1;
      ctrl_o.adc_pin_irq_en            = 1'b1;
      ctrl_o.sram_upper_pwr            = 1'b1;
      ctrl_o.sram_upper_part_pwr       = 1'b1;
      ctrl_o.sram_lower_pwr            = 1'b1;
      ctrl_o.sysreg_file_pwr           = 1'b1;
    end else begin
      ctrl_o.lp_periph_en    = 1'b1;
      ctrl_o.pin_hold        = 1'b1;
      ctrl_o.sysreg_file_pwr = 1'b1;
      case (mode_i)
        lpsm_pkg::LPSM_MODE_VLP_STOP: begin
          ctrl_o.async_wakeup_irq_ctrl_en = 1'b1;
          ctrl_o.adc_pin_irq_en           = 1'b1;
          ctrl_o.sram_upper_pwr           = 1'b1;
          ctrl_o.sram_upper_part_pwr      = 1'b1;
          ctrl_o.sram_lower_pwr           = 1'b1;
        end
        lpsm_pkg::LPSM_MODE_LL_STOP, lpsm_pkg::LPSM_MODE_VLL3: begin
          ctrl_o.low_leakage_wakeup_unit_en = 1'b1;
          ctrl_o.sram_upper_pwr             = 1'b1;
          ctrl_o.sram_upper_part_pwr        = 1'b1;
          ctrl_o.sram_lower_pwr             = 1'b1;
        end
        lpsm_pkg::LPSM_MODE_VLL2: begin
          ctrl_o.low_leakage_wakeup_unit_en = 1'b1;
          ctrl_o.sram_upper_part_pwr        = 1'b1;
        end
        default: begin
          ctrl_o.low_leakage_wakeup_unit_en = 1'b1;
        end
      endcase
    end
  end

endmodule : lpsm_ctrl_map

// ---- hdl/lpsm_top.sv ----
`timescale 1ns/100ps
module lpsm_top #(
  parameter int unsigned RSTFLOW_CYC = lpsm_pkg::LPSM_RSTFLOW_CYC
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 wait_for_interrupt_instr_i,
  input  wire logic                 deep_sleep_i,
  input  wire lpsm_pkg::lpsm_mode_t mode_sel_i,
  input  wire logic                 irq_pending_i,
  input  wire logic                 async_wake_i,
  input  wire logic                 lwu_wake_i,
  input  wire logic                 lwu_flag_clr_i,
  input  wire logic                 power_up_i,
  output lpsm_pkg::lpsm_ctrl_t      ctrl_o,
  output lpsm_pkg::lpsm_state_t     state_o,
  output logic                      wake_irq_o,
  output logic                      lwu_flag_o,
  output logic                      chip_reset_o
);

  // the flow counter is 16 bits wide
  if (RSTFLOW_CYC < 1 || RSTFLOW_CYC > 65535) begin : g_bad_rstflow
    $error("RSTFLOW_CYC out of range");
  end

  lpsm_pkg::lpsm_state_t state;
  lpsm_pkg::lpsm_state_t next_state;
  lpsm_pkg::lpsm_mode_t  mode;
  lpsm_pkg::lpsm_ctrl_t  next_ctrl;
  logic [15:0]           cnt;
  logic [1:0]            aw_s;
  logic [1:0]            lw_s;
  logic [1:0]            pu_s;
  logic                  aw;
  logic                  lw;
  logic                  pu;
  logic                  wake_ev;
  logic                  cnt_done;

  // wake sources come from always-on domains, synchronise first
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_s <= 2'h0;
      lw_s <= 2'h0;
      pu_s <= 2'h0;
    end else begin
      aw_s <= {aw_s[0], async_wake_i};
      lw_s <= {lw_s[0], lwu_wake_i};
      pu_s <= {pu_s[0], power_up_i};
    end
  end
  assign aw = aw_s[1];
  assign lw = lw_s[1];
  assign pu = pu_s[1];

  always_comb begin
    wake_ev = 1'b0;
    case (mode)
      lpsm_pkg::LPSM_MODE_VLP_STOP: wake_ev = aw;
      lpsm_pkg::LPSM_MODE_BATT: wake_ev = 1'b0;
      default:                  wake_ev = lw;
    endcase
  end

  assign cnt_done = (cnt == 16'(RSTFLOW_CYC - 1));

  always_comb begin
    next_state = state;
    case (state)
      lpsm_pkg::LPSM_ST_RUN: begin
        if (wait_for_interrupt_instr_i) begin
          if (!deep_sleep_i) next_state = lpsm_pkg::LPSM_ST_WAIT;
          else if (mode_sel_i == lpsm_pkg::LPSM_MODE_BATT) next_state = lpsm_pkg::LPSM_ST_OFF;
          else if (mode_sel_i != lpsm_pkg::LPSM_MODE_RUN) next_state = lpsm_pkg::LPSM_ST_STOP;
        end
      end
      lpsm_pkg::LPSM_ST_WAIT: begin
        if (irq_pending_i) next_state = lpsm_pkg::LPSM_ST_RUN;
      end
      lpsm_pkg::LPSM_ST_STOP: begin
        if (wake_ev) begin
          if (mode == lpsm_pkg::LPSM_MODE_VLP_STOP || mode == lpsm_pkg::LPSM_MODE_LL_STOP) begin
            next_state = lpsm_pkg::LPSM_ST_RUN;
          end else begin
            next_state = lpsm_pkg::LPSM_ST_RSTFLOW;
          end
        end
      end
      lpsm_pkg::LPSM_ST_RSTFLOW: begin
        if (cnt_done) next_state = lpsm_pkg::LPSM_ST_RUN;
      end
      lpsm_pkg::LPSM_ST_OFF: begin
        if (pu) next_state = lpsm_pkg::LPSM_ST_RSTFLOW;
      end
      default: next_state = lpsm_pkg::LPSM_ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) state <= lpsm_pkg::LPSM_ST_RUN;
    else         state <= next_state;
  end

  // mode latched at entry so a later write cannot change a stop in progress
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= lpsm_pkg::LPSM_MODE_RUN;
    end else if (state == lpsm_pkg::LPSM_ST_RUN && next_state != lpsm_pkg::LPSM_ST_RUN) begin
      mode <= deep_sleep_i ? mode_sel_i : lpsm_pkg::LPSM_MODE_RUN;
    end else if (next_state == lpsm_pkg::LPSM_ST_RUN) begin
      mode <= lpsm_pkg::LPSM_MODE_RUN;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt <= 16'h0000;
    else if (state == lpsm_pkg::LPSM_ST_RSTFLOW && !cnt_done) cnt <= cnt + 16'h0001;
    else cnt <= 16'h0000;
  end

  // flag set wins over software clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) lwu_flag_o <= 1'b0;
    else if (state == lpsm_pkg::LPSM_ST_STOP && wake_ev && mode != lpsm_pkg::LPSM_MODE_VLP_STOP)
      lwu_flag_o <= 1'b1;
    else if (lwu_flag_clr_i) lwu_flag_o <= 1'b0;
  end

  // one-cycle interrupt pulse to resume run from the retention stops
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) wake_irq_o <= 1'b0;
    else wake_irq_o <= (state == lpsm_pkg::LPSM_ST_STOP) && wake_ev &&
                       (mode == lpsm_pkg::LPSM_MODE_VLP_STOP || mode == lpsm_pkg::LPSM_MODE_LL_STOP);
  end

  // the flow holds the chip in reset; retained rams stay powered but pin hold is released
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) chip_reset_o <= 1'b0;
    else chip_reset_o <= (next_state == lpsm_pkg::LPSM_ST_RSTFLOW);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) state_o <= lpsm_pkg::LPSM_ST_RUN;
    else state_o <= next_state;
  end

  lpsm_pkg::lpsm_mode_t next_mode;
  assign next_mode = (state == lpsm_pkg::LPSM_ST_RUN && next_state != lpsm_pkg::LPSM_ST_RUN && deep_sleep_i)
                     ? mode_sel_i : mode;

  lpsm_ctrl_map u_map (
    .state_i (next_state),
    .mode_i  (next_mode),
    .ctrl_o  (next_ctrl)
  );

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) ctrl_o <= lpsm_pkg::LPSM_CTRL_RESET;
    else ctrl_o <= next_ctrl;
  end

  AST_NO_ENTRY_WITHOUT_WAIT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_RUN && !wait_for_interrupt_instr_i |=> state != lpsm_pkg::LPSM_ST_STOP)
    else $error("stop entered without wait instruction");
  AST_VLP_STOP_CTRL: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_VLP_STOP |->
    ctrl_o.async_wakeup_irq_ctrl_en && !ctrl_o.nested_vector_irq_ctrl_en && !ctrl_o.periph_clk_en)
    else $error("very low power stop controls wrong");
  AST_VLP_STOP_KEEP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_VLP_STOP |->
    ctrl_o.adc_pin_irq_en && ctrl_o.sram_lower_pwr && ctrl_o.pin_hold)
    else $error("very low power stop retention wrong");
  AST_LL_WAKE_PATH: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode != lpsm_pkg::LPSM_MODE_VLP_STOP |->
    ctrl_o.low_leakage_wakeup_unit_en && !ctrl_o.async_wakeup_irq_ctrl_en && !ctrl_o.nested_vector_irq_ctrl_en)
    else $error("low leakage wake path wrong");
  AST_LL_STOP_RESUME: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_LL_STOP && lw |=>
    wake_irq_o && state == lpsm_pkg::LPSM_ST_RUN && !chip_reset_o)
    else $error("low leakage stop resume wrong");
  AST_VLL_RESET_FLOW: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && lw && mode inside {lpsm_pkg::LPSM_MODE_VLL3, lpsm_pkg::LPSM_MODE_VLL2,
    lpsm_pkg::LPSM_MODE_VLL1} |=> chip_reset_o && lwu_flag_o ##1 lwu_flag_o || $past(lwu_flag_clr_i))
    else $error("reset flow wrong");
  AST_VLL3_SRAM: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_VLL3 |->
    ctrl_o.sram_upper_pwr && ctrl_o.sram_lower_pwr)
    else $error("level 3 sram wrong");
  AST_VLL2_SRAM: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_VLL2 |->
    !ctrl_o.sram_lower_pwr && !ctrl_o.sram_upper_pwr && ctrl_o.sram_upper_part_pwr)
    else $error("level 2 sram wrong");
  AST_VLL1_SRAM: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_VLL1 |->
    !ctrl_o.sram_upper_pwr && !ctrl_o.sram_lower_pwr &&
    !ctrl_o.sram_upper_part_pwr && ctrl_o.sysreg_file_pwr && ctrl_o.backup_reg_file_pwr)
    else $error("level 1 power wrong");
  AST_BATTERY_OFF: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_OFF |-> !ctrl_o.core_pwr && ctrl_o.backup_reg_file_pwr)
    else $error("battery state power wrong");
  AST_RUN_SELECT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_RUN && wait_for_interrupt_instr_i && deep_sleep_i &&
    mode_sel_i == lpsm_pkg::LPSM_MODE_RUN |=> state == lpsm_pkg::LPSM_ST_RUN)
    else $error("run selection left run");

  COV_VLP_STOP: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_VLP_STOP ##1 state == lpsm_pkg::LPSM_ST_RUN);
  COV_LL_STOP: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_STOP && mode == lpsm_pkg::LPSM_MODE_LL_STOP ##1 wake_irq_o);
  COV_RSTFLOW: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == lpsm_pkg::LPSM_ST_RSTFLOW ##1 state == lpsm_pkg::LPSM_ST_RUN);
  COV_BAT: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) state == lpsm_pkg::LPSM_ST_OFF);

endmodule : lpsm_top

// ---- verif/lpsm_core_model.sv ----
`timescale 1ns/100ps
// core and wakeup sources; every request is launched by nonblocking assignment at a rising edge
module lpsm_core_model (
  input  wire logic           sys_clk_i,
  input  wire logic           wake_irq_i,
  output logic                wait_instr_o,
  output logic                deep_sleep_o,
  output lpsm_pkg::lpsm_mode_t mode_sel_o,
  output logic                irq_pending_o,
  output logic                async_wake_o,
  output logic                lwu_wake_o,
  output logic                lwu_flag_clr_o,
  output logic                power_up_o
);
  int unsigned isr_cnt;

  initial begin
    wait_instr_o    = 1'b0;
    deep_sleep_o    = 1'b0;
    mode_sel_o      = lpsm_pkg::LPSM_MODE_RUN;
    irq_pending_o   = 1'b0;
    async_wake_o    = 1'b0;
    lwu_wake_o      = 1'b0;
    lwu_flag_clr_o  = 1'b0;
    power_up_o      = 1'b0;
    isr_cnt         = 0;
  end

  // wakeup interrupt is never masked, so every wake pulse enters the service routine
  always @(posedge sys_clk_i) begin
    if (wake_irq_i === 1'b1) begin
      isr_cnt <= isr_cnt + 1;
    end
  end

  // the only way into wait or stop: one wait-for-interrupt pulse
  task automatic enter(input lpsm_pkg::lpsm_mode_t mode, input logic deep);
    @(posedge sys_clk_i);
    mode_sel_o   <= mode;
    deep_sleep_o <= deep;
    wait_instr_o <= 1'b1;
    @(posedge sys_clk_i);
    wait_instr_o <= 1'b0;
  endtask : enter

  // kind 0 pending irq, 1 async wake, 2 wakeup unit, 3 power up
  task automatic set_wake(input int kind, input logic val);
    @(posedge sys_clk_i);
    case (kind)
      0: irq_pending_o <= val;
      1: async_wake_o <= val;
      2: lwu_wake_o <= val;
      default: power_up_o <= val;
    endcase
  endtask : set_wake

  task automatic clr_flag();
    @(posedge sys_clk_i);
    lwu_flag_clr_o <= 1'b1;
    @(posedge sys_clk_i);
    lwu_flag_clr_o <= 1'b0;
  endtask : clr_flag
endmodule : lpsm_core_model

// ---- verif/tb.sv ----
`timescale 1ns/100ps
module tb;
  localparam int unsigned RF = 4;
  // bits from msb: periph lv_detect nested async wake_unit lp adc sram_u part sram_l sysreg backup pin core
  localparam logic [13:0] KM [7] = '{14'h2800, 14'h3DD2, 14'h2B52, 14'h2B52, 14'h2B32, 14'h2B7C, 14'h287D};
  localparam logic [13:0] EV [7] = '{14'h2800, 14'h05D2, 14'h0352, 14'h0352, 14'h0322, 14'h030C, 14'h0004};
  logic                  sys_clk_i;
  logic                  rstn_i;
  logic                  wait_instr;
  logic                  deep;
  lpsm_pkg::lpsm_mode_t  msel;
  logic                  irqp;
  logic                  awake;
  logic                  lwake;
  logic                  fclr;
  logic                  pup;
  lpsm_pkg::lpsm_ctrl_t  ctrl;
  lpsm_pkg::lpsm_state_t st;
  logic                  wirq;
  logic                  flag;
  logic                  crst;
  int                    num_errors;
  int                    compares;

  always #25 sys_clk_i = ~sys_clk_i;

  lpsm_core_model i_core (.sys_clk_i(sys_clk_i), .wake_irq_i(wirq), .wait_instr_o(wait_instr), .deep_sleep_o(deep),
    .mode_sel_o(msel), .irq_pending_o(irqp), .async_wake_o(awake), .lwu_wake_o(lwake),
    .lwu_flag_clr_o(fclr), .power_up_o(pup));
  lpsm_top #(.RSTFLOW_CYC(RF)) i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .wait_for_interrupt_instr_i(wait_instr),
    .deep_sleep_i(deep), .mode_sel_i(msel), .irq_pending_i(irqp), .async_wake_i(awake), .lwu_wake_i(lwake),
    .lwu_flag_clr_i(fclr), .power_up_i(pup), .ctrl_o(ctrl), .state_o(st), .wake_irq_o(wirq),
    .lwu_flag_o(flag), .chip_reset_o(crst));

  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic chk_ctrl(input lpsm_pkg::lpsm_mode_t m);
    chk((ctrl & KM[m]) === EV[m], $sformatf("ctrl map wrong in mode %0d", m));
  endtask : chk_ctrl

  // bounded wait for a state, checked just after each edge
  task automatic wait_st(input lpsm_pkg::lpsm_state_t s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (st === s) return;
    end
    chk(1'b0, "state wait timed out");
    test_done();
  endtask : wait_st

  task automatic go(input lpsm_pkg::lpsm_mode_t m, input lpsm_pkg::lpsm_state_t s);
    i_core.enter(m, 1'b1);
    #1;
    chk(st === s, "mode entry state wrong");
    chk_ctrl(m);
  endtask : go

  task automatic t_reset();
    chk(st === lpsm_pkg::LPSM_ST_RUN && flag === 1'b0 && crst === 1'b0, "reset outputs wrong");
    chk_ctrl(lpsm_pkg::LPSM_MODE_RUN);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_ctrl(lpsm_pkg::LPSM_MODE_RUN);
  endtask : t_reset

  task automatic t_run_and_wait();
    i_core.set_wake(2, 1'b1);
    i_core.enter(lpsm_pkg::LPSM_MODE_RUN, 1'b1);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk(st === lpsm_pkg::LPSM_ST_RUN, "left run without a stop mode");
    i_core.set_wake(2, 1'b0);
    i_core.enter(lpsm_pkg::LPSM_MODE_LL_STOP, 1'b0);
    #1;
    chk(st === lpsm_pkg::LPSM_ST_WAIT, "wait not entered");
    i_core.set_wake(0, 1'b1);
    wait_st(lpsm_pkg::LPSM_ST_RUN, 6);
    i_core.set_wake(0, 1'b0);
  endtask : t_run_and_wait

  task automatic t_vlp_stop();
    go(lpsm_pkg::LPSM_MODE_VLP_STOP, lpsm_pkg::LPSM_ST_STOP);
    i_core.set_wake(1, 1'b1);
    wait_st(lpsm_pkg::LPSM_ST_RUN, 8);
    chk(wirq === 1'b1 && flag === 1'b0, "async wake did not interrupt");
    i_core.set_wake(1, 1'b0);
    #1;
    chk(wirq === 1'b0, "wake pulse longer than one cycle");
  endtask : t_vlp_stop

  task automatic t_ll_stop();
    int unsigned n0;
    n0 = i_core.isr_cnt;
    go(lpsm_pkg::LPSM_MODE_LL_STOP, lpsm_pkg::LPSM_ST_STOP);
    i_core.set_wake(1, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk(st === lpsm_pkg::LPSM_ST_STOP, "async wake left low leakage stop");
    i_core.set_wake(1, 1'b0);
    i_core.set_wake(2, 1'b1);
    wait_st(lpsm_pkg::LPSM_ST_RUN, 8);
    chk(wirq === 1'b1 && crst === 1'b0, "low leakage wake not by interrupt");
    i_core.set_wake(2, 1'b0);
    #1;
    chk(i_core.isr_cnt === n0 + 1, "service routine count wrong");
    i_core.clr_flag();
    #1;
    chk(flag === 1'b0, "wakeup flag not cleared");
  endtask : t_ll_stop

  task automatic t_vlls(input lpsm_pkg::lpsm_mode_t m);
    int n;
    go(m, lpsm_pkg::LPSM_ST_STOP);
    chk(flag === 1'b0, "flag set before the wake");
    i_core.set_wake(2, 1'b1);
    wait_st(lpsm_pkg::LPSM_ST_RSTFLOW, 8);
    chk(crst === 1'b1 && flag === 1'b1, "reset flow or flag missing");
    n = 0;
    while (crst === 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(n == RF && st === lpsm_pkg::LPSM_ST_RUN, "reset flow length wrong");
    chk(flag === 1'b1, "flag lost after reset flow");
    i_core.set_wake(2, 1'b0);
    i_core.clr_flag();
    #1;
    chk(flag === 1'b0, "flag not cleared");
  endtask : t_vlls

  task automatic t_batt();
    go(lpsm_pkg::LPSM_MODE_BATT, lpsm_pkg::LPSM_ST_OFF);
    i_core.set_wake(2, 1'b1);
    i_core.set_wake(1, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk(st === lpsm_pkg::LPSM_ST_OFF, "battery state left by a wake");
    i_core.set_wake(2, 1'b0);
    i_core.set_wake(1, 1'b0);
    i_core.set_wake(3, 1'b1);
    wait_st(lpsm_pkg::LPSM_ST_RSTFLOW, 8);
    wait_st(lpsm_pkg::LPSM_ST_RUN, RF + 4);
    i_core.set_wake(3, 1'b0);
    #1;
    chk(st === lpsm_pkg::LPSM_ST_RUN, "power up did not reach run");
  endtask : t_batt

  // reset in the middle of a stop must bring back normal run
  task automatic t_mid_reset();
    go(lpsm_pkg::LPSM_MODE_VLL2, lpsm_pkg::LPSM_ST_STOP);
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    #1;
    chk(st === lpsm_pkg::LPSM_ST_RUN && crst === 1'b0, "reset in stop did not return to run");
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset();
  endtask : t_mid_reset

  initial begin
    sys_clk_i  = 1'b0;
    rstn_i     = 1'b0;
    num_errors = 0;
    compares   = 0;
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_run_and_wait();
    t_vlp_stop();
    t_ll_stop();
    t_vlls(lpsm_pkg::LPSM_MODE_VLL3);
    t_vlls(lpsm_pkg::LPSM_MODE_VLL2);
    t_vlls(lpsm_pkg::LPSM_MODE_VLL1);
    t_batt();
    t_mid_reset();
    test_done();
  end
endmodule : tb
